// File: design/ascp_pkg.sv
package ascp_pkg;
	// System clock
	localparam int unsigned CLK_HZ = 125000000;
	// Modulator rates in normal and turbo operation
	localparam int unsigned MOD_HZ_NORMAL = 256000;
	localparam int unsigned MOD_HZ_TURBO = 512000;
	localparam int unsigned MOD_CYC_NORMAL = CLK_HZ / MOD_HZ_NORMAL;
	localparam int unsigned MOD_CYC_TURBO = CLK_HZ / MOD_HZ_TURBO;
	localparam logic [9:0] MOD_DIV_NORMAL = 10'(MOD_CYC_NORMAL);
	localparam logic [9:0] MOD_DIV_TURBO = 10'(MOD_CYC_TURBO);
	// Ready pulse width before a fresh result, in modulator periods
	localparam logic [1:0] RDY_PULSE_MOD = 2'h2;
	// Result format
	localparam int unsigned RES_W = 16;
	localparam int unsigned RAW_W = 24;
	localparam logic [15:0] RES_POS_FULL = 16'h7FFF;
	localparam logic [15:0] RES_NEG_FULL = 16'h8000;
	localparam int unsigned FIFO_DEPTH = 8;
	// Configuration register defaults and field positions
	localparam logic [7:0] CFG_DEFAULT = 8'h00;
	localparam int unsigned CFG_MODE_REG = 1;
	localparam int unsigned CFG_TURBO_BIT = 4;
	localparam int unsigned CFG_CONT_BIT = 2;
	localparam int unsigned CFG_RDYM_REG = 3;
	localparam int unsigned CFG_RDYM_BIT = 1;
	// Command byte patterns
	localparam logic [7:0] CMD_RESET = 8'h06;
	localparam logic [7:0] CMD_START = 8'h08;
	localparam logic [7:0] CMD_SLEEP = 8'h02;
	localparam logic [3:0] CMD_RDATA_HI = 4'h1;
	localparam logic [3:0] CMD_REGISTER_READ_CMD_HI = 4'h2;
	localparam logic [3:0] CMD_REGISTER_WRITE_CMD_HI = 4'h4;

	typedef logic [3:0][7:0] ascp_cfg_t;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic din;
	} ascp_pins_t;

	typedef enum logic [1:0] {
		ST_CMD = 2'b00,
		ST_RDDATA = 2'b01,
		ST_RDREG = 2'b10,
		ST_WRREG = 2'b11
	} ascp_ser_t;

	typedef enum logic [1:0] {
		RD_HIGH = 2'b00,
		RD_LOW = 2'b01,
		RD_PULSE = 2'b10
	} ascp_rdy_t;
endpackage : ascp_pkg

// File: design/ascp_fifo.sv
`timescale 1ns/10ps
module ascp_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam int unsigned CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic ready_q, ready_d;
	logic push, pop;

	assign push = in_valid_i && ready_q;
	assign pop = out_valid_o && out_ready_i;
	assign in_ready_o = ready_q;
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem_q[rd_q];

	always_comb begin
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (push) begin
			wr_d = (wr_q == LAST) ? '0 : wr_q + AW'(1);
		end
		if (pop) begin
			rd_d = (rd_q == LAST) ? '0 : rd_q + AW'(1);
		end
		if (push && !pop) begin
			cnt_d = cnt_q + CW'(1);
		end else if (pop && !push) begin
			cnt_d = cnt_q - CW'(1);
		end
		// Registered ready keeps the source path short
		ready_d = (cnt_d != FULL);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			ready_q <= 1'b0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			ready_q <= ready_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end
endmodule : ascp_fifo

// File: design/ascp_serial_port.sv
// Behaviour
// - Select high: reset interface, tristate output
// - Ready falls on result, rises on SCLK
// - Unread in continuous: pulse high one to two periods
// - Dedicated ready output always driven
// - Sample input on falling edges only
// - Shift output data on rising edges
// - Shared line mirrors ready fall when selected
// - Incomplete command times out, interface resets
// - Results are 16-bit two's complement
// - Overrange saturates to 7FFF or 8000
// - Reset command restores default settings
// - Start command restarts single conversion
// - Start command restarts continuous conversions
// - Decode sleep and read-data commands
// - Decode register read and write nibbles
// - rr picks start register, nn count-1
// - Mode one: launch rising, capture falling
// - Register write commits on final falling edge
`timescale 1ns/10ps
module ascp_serial_port #(
	parameter int unsigned TIMEOUT_NORMAL_MOD = 13955,
	parameter int unsigned TIMEOUT_TURBO_MOD = 27910
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire ascp_pkg::ascp_pins_t pins_i,
	output logic sdo_o,
	output logic sdo_oe_n_o,
	output logic result_ready_out_n_o,
	input wire logic conv_valid_i,
	input wire logic [ascp_pkg::RAW_W-1:0] conv_raw_i,
	output logic conv_ready_o,
	output ascp_pkg::ascp_cfg_t cfg_o,
	output logic start_o,
	output logic dev_reset_o,
	output logic sleep_o
);
	import ascp_pkg::*;

	localparam logic signed [RAW_W-1:0] RAW_MAX = RAW_W'($signed(RES_POS_FULL));
	localparam logic signed [RAW_W-1:0] RAW_MIN = -RAW_W'(32768);

	ascp_pins_t s1_q, s2_q;
	logic sclk_d1_q;
	logic cs_s, sclk_rise, sclk_fall, din_s;

	// Second stage alone looks at the first
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_q <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
			s2_q <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
			sclk_d1_q <= 1'b0;
		end else begin
			s1_q <= pins_i;
			s2_q <= s1_q;
			sclk_d1_q <= s2_q.sclk;
		end
	end

	assign cs_s = s2_q.cs_n;
	assign din_s = s2_q.din;
	assign sclk_rise = !cs_s && s2_q.sclk && !sclk_d1_q;
	assign sclk_fall = !cs_s && !s2_q.sclk && sclk_d1_q;

	// Modulator tick, rate follows the turbo bit
	logic [9:0] div_q, div_d;
	logic mod_tick, turbo;
	assign turbo = cfg_o[CFG_MODE_REG][CFG_TURBO_BIT];
	assign mod_tick = (div_q == 10'h000);
	always_comb begin
		div_d = mod_tick ? (turbo ? MOD_DIV_TURBO : MOD_DIV_NORMAL) - 10'h001 : div_q - 10'h001;
	end
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_q <= 10'h000;
		end else begin
			div_q <= div_d;
		end
	end

	logic [RES_W-1:0] sat_word;
	always_comb begin
		if ($signed(conv_raw_i) > RAW_MAX) begin
			sat_word = RES_POS_FULL;
		end else if ($signed(conv_raw_i) < RAW_MIN) begin
			sat_word = RES_NEG_FULL;
		end else begin
			sat_word = conv_raw_i[RES_W-1:0];
		end
	end

	logic fifo_vld, fifo_pop, fifo_rdy;
	logic [RES_W-1:0] fifo_word;
	ascp_fifo #(
		.WIDTH(RES_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(ref_clk_i),
		.rst_i(rst_i),
		.in_valid_i(conv_valid_i),
		.in_ready_o(fifo_rdy),
		.in_data_i(sat_word),
		.out_valid_o(fifo_vld),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_word)
	);

	// Serial engine and ready machine state
	ascp_ser_t st_q, st_d;
	ascp_rdy_t rdy_q, rdy_d;
	logic [2:0] bit_q, bit_d;
	logic byte_q, byte_d;
	logic [7:0] rx_q, rx_d, rx_byte;
	logic [15:0] buf_q, buf_d;
	// Spare top stage repeats the MSB so the first rise launches it, as mode one wants
	logic [16:0] tx_q, tx_d;
	logic act_q, act_d;
	logic [1:0] ptr_q, ptr_d, left_q, left_d, pcnt_q, pcnt_d;
	ascp_cfg_t cfg_d, pend_q, pend_d;
	logic [14:0] to_q, to_d;
	logic start_d, reset_d, sleep_d, rdy_n_d, sdo_d, rdrdy_q;
	logic to_hit, load_ok, load_new;

	assign rx_byte = {rx_q[6:0], din_s};
	assign to_hit = to_q >= (turbo ? 15'(TIMEOUT_TURBO_MOD) : 15'(TIMEOUT_NORMAL_MOD));
	// Swap the result only when deselected or at bit 0 in the command state, never on a rising edge
	assign load_ok = !sclk_rise && (cs_s || (st_q == ST_CMD && bit_q == 3'h0));

	always_comb begin
		rdy_d = rdy_q;
		pcnt_d = pcnt_q;
		buf_d = buf_q;
		load_new = 1'b0;
		rdy_n_d = result_ready_out_n_o;
		unique case (rdy_q)
			RD_HIGH: begin
				rdy_n_d = 1'b1;
				if (fifo_vld && load_ok) begin
					load_new = 1'b1;
					buf_d = fifo_word;
					rdy_d = RD_LOW;
					rdy_n_d = 1'b0;
				end
			end
			RD_LOW: begin
				if (sclk_rise) begin
					rdy_d = RD_HIGH;
					rdy_n_d = 1'b1;
				end else if (fifo_vld) begin
					rdy_d = RD_PULSE;
					pcnt_d = 2'h0;
					rdy_n_d = 1'b1;
				end
			end
			RD_PULSE: begin
				rdy_n_d = 1'b1;
				if (mod_tick) begin
					pcnt_d = pcnt_q + 2'h1;
					if (pcnt_q + 2'h1 == RDY_PULSE_MOD) begin
						rdy_d = RD_HIGH;
					end
				end
			end
			default: begin
				rdy_d = RD_HIGH;
				rdy_n_d = 1'b1;
			end
		endcase
	end
	assign fifo_pop = load_new;

	always_comb begin
		st_d = st_q;
		bit_d = bit_q;
		byte_d = byte_q;
		rx_d = rx_q;
		tx_d = tx_q;
		act_d = act_q;
		ptr_d = ptr_q;
		left_d = left_q;
		cfg_d = cfg_o;
		pend_d = pend_q;
		to_d = to_q;
		start_d = 1'b0;
		reset_d = 1'b0;
		sleep_d = sleep_o;
		if (cs_s || to_hit) begin
			st_d = ST_CMD;
			bit_d = 3'h0;
			byte_d = 1'b0;
			act_d = 1'b0;
			to_d = 15'h0000;
		end else begin
			if (st_q != ST_CMD || bit_q != 3'h0) begin
				to_d = mod_tick ? to_q + 15'h0001 : to_q;
			end else begin
				to_d = 15'h0000;
			end
			if (sclk_rise) begin
				tx_d = {tx_q[15:0], 1'b0};
				act_d = 1'b1;
			end
			// Capture on falling edge, MSB first
			if (sclk_fall) begin
				rx_d = rx_byte;
				bit_d = bit_q + 3'h1;
				if (bit_q == 3'h7) begin
					to_d = 15'h0000;
					unique case (st_q)
						ST_CMD: begin
							if (rx_byte[7:1] == CMD_RESET[7:1]) begin
								reset_d = 1'b1;
								cfg_d = {4{CFG_DEFAULT}};
								sleep_d = 1'b0;
							end else if (rx_byte[7:1] == CMD_START[7:1]) begin
								start_d = 1'b1;
								sleep_d = 1'b0;
							end else if (rx_byte[7:1] == CMD_SLEEP[7:1]) begin
								sleep_d = 1'b1;
							end else if (rx_byte[7:4] == CMD_RDATA_HI) begin
								tx_d = {buf_q[15], buf_q};
								st_d = ST_RDDATA;
								byte_d = 1'b0;
							end else if (rx_byte[7:4] == CMD_REGISTER_READ_CMD_HI) begin
								ptr_d = rx_byte[3:2];
								left_d = rx_byte[1:0];
								tx_d = {cfg_o[rx_byte[3:2]][7], cfg_o[rx_byte[3:2]], 8'h00};
								st_d = ST_RDREG;
							end else if (rx_byte[7:4] == CMD_REGISTER_WRITE_CMD_HI) begin
								ptr_d = rx_byte[3:2];
								left_d = rx_byte[1:0];
								pend_d = cfg_o;
								st_d = ST_WRREG;
							end
						end
						ST_RDDATA: begin
							byte_d = 1'b1;
							if (byte_q) begin
								st_d = ST_CMD;
							end
						end
						ST_RDREG: begin
							if (left_q == 2'h0) begin
								st_d = ST_CMD;
							end else begin
								ptr_d = ptr_q + 2'h1;
								left_d = left_q - 2'h1;
								tx_d = {cfg_o[ptr_q + 2'h1][7], cfg_o[ptr_q + 2'h1], 8'h00};
							end
						end
						ST_WRREG: begin
							pend_d[ptr_q] = rx_byte;
							ptr_d = ptr_q + 2'h1;
							left_d = left_q - 2'h1;
							if (left_q == 2'h0) begin
								cfg_d = pend_d;
								start_d = 1'b1;
								sleep_d = 1'b0;
								st_d = ST_CMD;
							end
						end
					endcase
				end
			end
			if (load_new) begin
				tx_d = {fifo_word[15], fifo_word};
				act_d = 1'b0;
			end
		end
		// Shared line shows ready until data shifting starts
		if (cfg_d[CFG_RDYM_REG][CFG_RDYM_BIT] && !act_d) begin
			sdo_d = rdy_n_d;
		end else begin
			sdo_d = tx_d[16];
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= ST_CMD;
			rdy_q <= RD_HIGH;
			bit_q <= 3'h0;
			byte_q <= 1'b0;
			rx_q <= 8'h00;
			tx_q <= 17'h00000;
			buf_q <= 16'h0000;
			act_q <= 1'b0;
			ptr_q <= 2'h0;
			left_q <= 2'h0;
			pcnt_q <= 2'h0;
			pend_q <= {4{CFG_DEFAULT}};
			cfg_o <= {4{CFG_DEFAULT}};
			to_q <= 15'h0000;
			start_o <= 1'b0;
			dev_reset_o <= 1'b0;
			sleep_o <= 1'b0;
			sdo_o <= 1'b1;
			sdo_oe_n_o <= 1'b1;
			result_ready_out_n_o <= 1'b1;
			conv_ready_o <= 1'b0;
			rdrdy_q <= 1'b0;
		end else begin
			st_q <= st_d;
			rdy_q <= rdy_d;
			bit_q <= bit_d;
			byte_q <= byte_d;
			rx_q <= rx_d;
			tx_q <= tx_d;
			buf_q <= buf_d;
			act_q <= act_d;
			ptr_q <= ptr_d;
			left_q <= left_d;
			pcnt_q <= pcnt_d;
			pend_q <= pend_d;
			cfg_o <= cfg_d;
			to_q <= to_d;
			start_o <= start_d;
			dev_reset_o <= reset_d;
			sleep_o <= sleep_d;
			sdo_o <= sdo_d;
			sdo_oe_n_o <= cs_s;
			result_ready_out_n_o <= rdy_n_d;
			conv_ready_o <= fifo_rdy;
			rdrdy_q <= (rdy_q == RD_PULSE);
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	sequence byte_end_s;
		sclk_fall && bit_q == 3'h7 && !to_hit;
	endsequence

	sequence cmd_byte_s(logic [6:0] pat);
		byte_end_s ##0 (st_q == ST_CMD && rx_byte[7:1] == pat);
	endsequence

	cs_hiz_a: assert property (cs_s |=> sdo_oe_n_o)
		else $error("shared line driven while deselected");
	rdy_rise_a: assert property (sclk_rise && rdy_q == RD_LOW |=> result_ready_out_n_o)
		else $error("ready did not return high on clock rise");
	rdy_pulse_a: assert property (rdrdy_q |-> result_ready_out_n_o)
		else $error("ready low during pre-result pulse");
	din_sample_a: assert property (sclk_fall && !to_hit |=> rx_q[0] == $past(din_s))
		else $error("input bit not captured on falling edge");
	tx_shift_a: assert property (sclk_rise && !load_new && !to_hit
		|=> tx_q == {$past(tx_q[15:0]), 1'b0})
		else $error("output not shifted on rising edge");
	rdym_mirror_a: assert property ($fell(result_ready_out_n_o) && !sdo_oe_n_o && !act_q
		&& cfg_o[CFG_RDYM_REG][CFG_RDYM_BIT] |-> !sdo_o)
		else $error("shared line did not fall with ready");
	timeout_rst_a: assert property (to_hit && !cs_s |=> st_q == ST_CMD && bit_q == 3'h0)
		else $error("interface not reset after timeout");
	sat_pos_a: assert property ($signed(conv_raw_i) > RAW_MAX |-> sat_word == RES_POS_FULL)
		else $error("positive overrange not saturated");
	sat_neg_a: assert property ($signed(conv_raw_i) < RAW_MIN |-> sat_word == RES_NEG_FULL)
		else $error("negative overrange not saturated");
	reset_cmd_a: assert property (cmd_byte_s(CMD_RESET[7:1]) |=> cfg_o == '0 && dev_reset_o)
		else $error("reset command did not restore defaults");
	start_cmd_a: assert property (cmd_byte_s(CMD_START[7:1]) |=> start_o ##1 !start_o)
		else $error("start command gave no single pulse");
	register_write_cmd_commit_a: assert property (byte_end_s ##0 (st_q == ST_WRREG && left_q == 2'h0)
		|=> cfg_o[$past(ptr_q)] == $past(rx_byte) && st_q == ST_CMD)
		else $error("register write not committed on last byte");
endmodule : ascp_serial_port

// File: tb/ascp_host_model.sv
`timescale 1ns/10ps
module ascp_host_model (
	input wire logic ref_clk_i,
	input wire logic sdo_i,
	input wire logic sdo_oe_n_i,
	output ascp_pkg::ascp_pins_t pins_o
);
	import ascp_pkg::*;
	// Half serial period in system cycles; raise it for a slow host
	int half = 5;
	initial pins_o = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : tick
	// Select moves only while clock rests
	task automatic select(input logic on);
		tick(half);
		pins_o.cs_n = ~on;
		pins_o.din = ~pins_o.din;
		tick(half);
	endtask : select
	// Launch on rise, capture on fall, rest low
	task automatic shift(input int nbits, input logic [15:0] tx, output logic [15:0] rx);
		rx = '0;
		for (int i = nbits - 1; i >= 0; i--) begin
			pins_o.sclk = 1'b1;
			pins_o.din = tx[i];
			tick(half);
			pins_o.sclk = 1'b0;
			rx[i] = sdo_oe_n_i ? 1'bz : sdo_i;
			tick(half);
		end
	endtask : shift
	task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
		logic [15:0] w;
		shift(8, {8'h00, tx}, w);
		rx = w[7:0];
	endtask : xbyte
endmodule : ascp_host_model

// File: tb/tb_ascp_serial_port.sv
`timescale 1ns/10ps
module tb_ascp_serial_port;
	import ascp_pkg::*;
	localparam int TO_N = 20;
	localparam int MOD_N = 488;
	localparam int TO_T = 40;
	logic ref_clk_i, rst_i, conv_valid_i, sdo, sdo_oe_n, rdy_n, conv_ready, sdo_line;
	logic start, dev_reset, sleep;
	logic [RAW_W-1:0] conv_raw_i;
	ascp_pins_t pins;
	ascp_cfg_t cfg;
	logic [15:0] w;
	logic [7:0] b;
	int n_fail = 0;
	int n_checks = 0;
	int n_start = 0;
	int n_rst = 0;
	assign sdo_line = sdo_oe_n ? 1'bz : sdo;
	ascp_serial_port #(
		.TIMEOUT_NORMAL_MOD(TO_N),
		.TIMEOUT_TURBO_MOD(TO_T)
	) i_ascp_serial_port (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.pins_i(pins),
		.sdo_o(sdo),
		.sdo_oe_n_o(sdo_oe_n),
		.result_ready_out_n_o(rdy_n),
		.conv_valid_i(conv_valid_i),
		.conv_raw_i(conv_raw_i),
		.conv_ready_o(conv_ready),
		.cfg_o(cfg),
		.start_o(start),
		.dev_reset_o(dev_reset),
		.sleep_o(sleep)
	);
	ascp_host_model i_ascp_host_model (
		.ref_clk_i(ref_clk_i),
		.sdo_i(sdo),
		.sdo_oe_n_i(sdo_oe_n),
		.pins_o(pins)
	);
	initial begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		if (start === 1'b1) n_start++;
		if (dev_reset === 1'b1) n_rst++;
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report
	initial begin
		int cyc = 0;
		forever begin
			@(posedge ref_clk_i);
			cyc++;
			if (cyc == 60000) begin
				n_fail++;
				final_report();
			end
		end
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic send1(input logic [7:0] c);
		i_ascp_host_model.select(1'b1);
		i_ascp_host_model.xbyte(c, b);
		i_ascp_host_model.select(1'b0);
	endtask : send1
	task automatic register_write_cmd(input logic [1:0] rr, input logic [1:0] nn, input ascp_cfg_t v);
		i_ascp_host_model.select(1'b1);
		i_ascp_host_model.xbyte({CMD_REGISTER_WRITE_CMD_HI, rr, nn}, b);
		for (int k = 0; k <= int'(nn); k++) i_ascp_host_model.xbyte(v[k], b);
		i_ascp_host_model.select(1'b0);
	endtask : register_write_cmd
	task automatic push(input logic [23:0] raw);
		for (int t = 0; t < 10 && conv_ready !== 1'b1; t++) begin
			@(posedge ref_clk_i);
			#1;
		end
		conv_raw_i = raw;
		conv_valid_i = 1'b1;
		@(posedge ref_clk_i);
		#1 conv_valid_i = 1'b0;
		repeat (2) @(posedge ref_clk_i);
		#1;
	endtask : push
	task automatic wait_rdy(output bit ok);
		// Sampled after the edge so a one-cycle low between pulses is not missed
		ok = 1'b0;
		for (int t = 0; t < 3000 && !ok; t++) begin
			@(posedge ref_clk_i);
			#1 ok = (rdy_n === 1'b0);
		end
	endtask : wait_rdy
	task automatic t_reset();
		for (int k = 0; k < 4; k++) check("cfg reset", {8'h00, cfg[k]}, 16'h0000);
		check("ready idle", {15'h0, rdy_n}, 16'h0001);
		check("line off", {15'h0, sdo_oe_n}, 16'h0001);
		check("sleep", {15'h0, sleep}, 16'h0000);
	endtask : t_reset
	task automatic t_regs();
		int s0 = n_start;
		logic [7:0] rexp [4] = '{8'hC3, 8'h00, 8'hA5, 8'h5A};
		// Start at register one, three bytes
		register_write_cmd(2'b01, 2'b10, {8'h00, 8'hC3, 8'h5A, 8'hA5});
		check("cfg low", cfg[1:0], 16'hA500);
		check("cfg high", cfg[3:2], 16'hC35A);
		check("write restart", 16'(n_start - s0), 16'h0001);
		i_ascp_host_model.half = 9;
		i_ascp_host_model.select(1'b1);
		i_ascp_host_model.xbyte({CMD_REGISTER_READ_CMD_HI, 4'hF}, b);
		for (int k = 0; k < 4; k++) begin
			i_ascp_host_model.xbyte(8'h00, b);
			check("reg read", {8'h00, b}, {8'h00, rexp[k]});
		end
		i_ascp_host_model.select(1'b0);
		i_ascp_host_model.half = 5;
		i_ascp_host_model.shift(16, {CMD_REGISTER_WRITE_CMD_HI, 4'h0, 8'hFF}, w);
		check("deselected line", w, 16'hZZZZ);
		check("cfg kept", {8'h00, cfg[0]}, 16'h0000);
	endtask : t_regs
	task automatic t_cmds();
		int s0 = n_start;
		send1(CMD_SLEEP | 8'h01);
		check("sleep on", {15'h0, sleep}, 16'h0001);
		send1(CMD_START | 8'h01);
		check("sleep off", {15'h0, sleep}, 16'h0000);
		check("start", 16'(n_start - s0), 16'h0001);
		send1(CMD_RESET | 8'h01);
		check("reset pulse", 16'(n_rst), 16'h0001);
		for (int k = 0; k < 4; k++) check("defaults", {8'h00, cfg[k]}, 16'h0000);
		repeat (6300) @(posedge ref_clk_i);
	endtask : t_cmds
	task automatic t_data();
		logic [23:0] raw [6] = '{24'h001234, 24'h012345, 24'hFF0000, 24'hFFFFFF,
			24'h007FFF, 24'hFF8000};
		logic [15:0] exp [6] = '{16'h1234, 16'h7FFF, 16'h8000, 16'hFFFF, 16'h7FFF, 16'h8000};
		bit ok;
		register_write_cmd(2'b11, 2'b00, {24'h000000, 8'h02});
		i_ascp_host_model.select(1'b1);
		for (int i = 0; i < 6; i++) begin
			push(raw[i]);
			wait_rdy(ok);
			check("ready fall", {15'h0, ok}, 16'h0001);
			check("line ready", {15'h0, sdo_line}, 16'h0000);
			i_ascp_host_model.shift(16, 16'h0000, w);
			check("word", w, exp[i]);
			check("ready back", {15'h0, rdy_n}, 16'h0001);
		end
		i_ascp_host_model.xbyte({CMD_RDATA_HI, 4'hA}, b);
		i_ascp_host_model.shift(16, 16'h0000, w);
		check("read by command", w, exp[5]);
		i_ascp_host_model.select(1'b0);
	endtask : t_data
	task automatic t_fifo();
		int n = 0;
		int hi = 0;
		logic [15:0] prev = '0;
		bit ok;
		for (int i = 0; i < 12 && conv_ready === 1'b1; i++) begin
			push(24'h000100 + 24'(i));
			n++;
		end
		check("buffer full", {15'h0, conv_ready}, 16'h0000);
		check("depth", 16'(n >= FIFO_DEPTH), 16'h0001);
		// Measure one whole pulse: from the short low of a load to the next load
		wait_rdy(ok);
		check("pulse start", {15'h0, ok}, 16'h0001);
		for (int t = 0; t < 3000 && rdy_n !== 1'b1; t++) begin
			@(posedge ref_clk_i);
			#1;
		end
		while (rdy_n === 1'b1 && hi < 3000) begin
			@(posedge ref_clk_i);
			#1;
			hi++;
		end
		// Tick-aligned pulse: between one and two periods plus phase
		check("pulse", 16'(hi >= MOD_N && hi <= 2 * MOD_N + 4), 16'h0001);
		i_ascp_host_model.select(1'b1);
		for (int i = 0; i < 16; i++) begin
			wait_rdy(ok);
			if (!ok) break;
			i_ascp_host_model.shift(16, 16'h0000, w);
			check("oldest first", 16'(w > prev), 16'h0001);
			prev = w;
		end
		i_ascp_host_model.select(1'b0);
		check("drained", {15'h0, conv_ready}, 16'h0001);
	endtask : t_fifo
	task automatic t_timeout();
		i_ascp_host_model.select(1'b1);
		i_ascp_host_model.shift(3, 16'h0007, w);
		repeat ((TO_N + 2) * MOD_N) @(posedge ref_clk_i);
		#1;
		i_ascp_host_model.xbyte({CMD_REGISTER_WRITE_CMD_HI, 4'h0}, b);
		i_ascp_host_model.xbyte(8'h3C, b);
		i_ascp_host_model.select(1'b0);
		check("after timeout", {8'h00, cfg[0]}, 16'h003C);
	endtask : t_timeout
	initial begin
		rst_i = 1'b1;
		conv_valid_i = 1'b0;
		conv_raw_i = '0;
		repeat (5) @(posedge ref_clk_i);
		#1 rst_i = 1'b0;
		repeat (4) @(posedge ref_clk_i);
		#1;
		t_reset();
		t_regs();
		t_cmds();
		t_data();
		t_fifo();
		t_timeout();
		final_report();
	end
endmodule : tb_ascp_serial_port
